// >>> hdl/vlsr_pkg.sv
// Constants, register map and types for the variable length shift register
// What this block does
// - Serial shift register whose active length is any whole count from 1 to 64.
// - Length is one plus the weights 1,2,4,8,16,32 of asserted length inputs, or of the register length field when CTRL_LEN_REG is set.
// - Serial input from first data input (fed word bit in software mode) when select high, second when low.
// - In pin mode, gate input blocks shifting, or its falling edge shifts while clock stays high.
// - Serial output from the last selected stage, plus its complement output.
// - Stored bits hold indefinitely without shift edges; no minimum clock rate.
package vlsr_pkg;

  localparam int          STAGES     = 64;
  localparam int          LEN_W      = 6;
  localparam int          FIFO_W     = 32;
  localparam int          FIFO_D     = 8;
  localparam int          BIT_CNT_W  = 5;
  localparam logic [4:0]  LAST_BIT   = 5'h1f;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_SHIFT_IN  = 8'h08;
  localparam logic [7:0]  ADDR_STAGES_LO = 8'h0c;
  localparam logic [7:0]  ADDR_STAGES_HI = 8'h10;

  localparam int          CTRL_LEN_LSB   = 0;
  localparam int          CTRL_SW_MODE   = 6;
  localparam int          CTRL_RUN       = 7;
  localparam int          CTRL_LEN_REG   = 8;
  localparam int          CTRL_W         = 9;
  localparam logic [8:0]  CTRL_RESET     = 9'h000;

  localparam int          STAT_Q         = 0;
  localparam int          STAT_EMPTY     = 1;
  localparam int          STAT_FULL      = 2;
  localparam int          STAT_BUSY      = 3;
  localparam int          STAT_LEN_LSB   = 8;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;

  typedef enum logic [0:0] {
    VLSR_IDLE  = 1'b0,
    VLSR_SHIFT = 1'b1
  } vlsr_feed_t;

endpackage

// >>> hdl/vlsr_top.sv
// Variable length shift register with word feed FIFO and AXI4-Lite registers
`timescale 1ns/100ps

module vlsr_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

  // Storage needs no reset; entries are only read once written
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module vlsr_top
  import vlsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        data_a,
  input  wire logic        data_b,
  input  wire logic        sel_a,
  input  wire logic        shift_clk,
  input  wire logic        clk_gate,
  input  wire logic        len_weight_one,
  input  wire logic        len_weight_two,
  input  wire logic        len_weight_four,
  input  wire logic        len_weight_eight,
  input  wire logic        len_weight_sixteen,
  input  wire logic        len_weight_thirtytwo,
  output logic             q,
  output logic             q_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import vlsr_pkg::*;

  logic [STAGES-1:0]   stage;
  logic [CTRL_W-1:0]   ctrl;
  logic [LEN_W-1:0]    len_code;
  logic                prev_clk;
  logic                prev_gate;
  logic                pin_shift;
  logic                sw_shift;
  logic                do_shift;
  logic                shift_bit;
  logic                in_a;
  vlsr_feed_t          feed;
  logic [FIFO_W-1:0]   feed_word;
  logic [BIT_CNT_W-1:0] feed_cnt;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [FIFO_W-1:0]   fifo_out_data;
  logic                aw_held;
  logic                w_held;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                wr_fire;
  logic                wr_push;
  logic [31:0]         rd_word;
  logic                rd_hit;

  // Length code is the pin binary weight sum, or the register field when CTRL_LEN_REG is set; active length is code plus one
  assign len_code = ctrl[CTRL_LEN_REG] ? ctrl[CTRL_LEN_LSB +: LEN_W] :
                    {len_weight_thirtytwo, len_weight_sixteen, len_weight_eight,
                     len_weight_four, len_weight_two, len_weight_one};

  // Edge detection on the sampled pins; inputs are synchronous to clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_clk  <= 1'b0;
      prev_gate <= 1'b0;
    end else begin
      prev_clk  <= shift_clk;
      prev_gate <= clk_gate;
    end
  end

  // Rising clock with gate low, or falling gate while clock held high
  assign pin_shift = !ctrl[CTRL_SW_MODE] &&
                     ((shift_clk && !prev_clk && !clk_gate) ||
                      (prev_gate && !clk_gate && shift_clk));

  assign sw_shift  = (feed == VLSR_SHIFT);
  assign do_shift  = pin_shift || sw_shift;

  // In software mode the first data input is replaced by the fed word bit
  assign in_a      = ctrl[CTRL_SW_MODE] ? feed_word[0] : data_a;
  assign shift_bit = sel_a ? in_a : data_b;

  // Stages hold without a shift, so there is no minimum pin clock rate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage <= '0;
    end else if (do_shift) begin
      stage <= {stage[STAGES-2:0], shift_bit};
    end
  end

  // Output taps the last stage of the selected length
  assign q   = stage[len_code];
  assign q_n = !q;

  // Feed engine drains the FIFO only while run is set, so software can stall it
  assign fifo_out_ready = (feed == VLSR_IDLE) && ctrl[CTRL_SW_MODE] && ctrl[CTRL_RUN];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      feed      <= VLSR_IDLE;
      feed_word <= '0;
      feed_cnt  <= '0;
    end else begin
      case (feed)
        VLSR_IDLE: begin
          if (fifo_out_valid && fifo_out_ready) begin
            feed      <= VLSR_SHIFT;
            feed_word <= fifo_out_data;
            feed_cnt  <= '0;
          end
        end
        VLSR_SHIFT: begin
          feed_word <= feed_word >> 1;
          feed_cnt  <= feed_cnt + 1'b1;
          if (feed_cnt == LAST_BIT) begin
            feed <= VLSR_IDLE;
          end
        end
        default: begin
          feed <= VLSR_IDLE;
        end
      endcase
    end
  end

  vlsr_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .in_data   (w_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // AXI4-Lite write side: address and data are caught in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  // A write to the shift-in register waits while the FIFO is full
  assign wr_fire = aw_held && w_held && !s_axi_bvalid &&
                   ((aw_addr != ADDR_SHIFT_IN) || fifo_in_ready);
  assign wr_push = aw_held && w_held && !s_axi_bvalid &&
                   (aw_addr == ADDR_SHIFT_IN) && fifo_in_ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_fire && aw_addr == ADDR_CTRL) begin
      if (w_strb[0]) begin
        ctrl[CTRL_RUN:0] <= w_data[CTRL_RUN:0];
      end
      if (w_strb[1]) begin
        ctrl[CTRL_LEN_REG] <= w_data[CTRL_LEN_REG];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_SHIFT_IN) ?
                      RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read side
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = DATA_ZERO;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL: begin
        rd_word[CTRL_W-1:0] = ctrl;
      end
      ADDR_STATUS: begin
        rd_word[STAT_Q]                       = q;
        rd_word[STAT_EMPTY]                   = !fifo_out_valid;
        rd_word[STAT_FULL]                    = !fifo_in_ready;
        rd_word[STAT_BUSY]                    = sw_shift;
        rd_word[STAT_LEN_LSB +: LEN_W]        = len_code;
      end
      ADDR_STAGES_LO: begin
        rd_word = stage[FIFO_W-1:0];
      end
      ADDR_STAGES_HI: begin
        rd_word = stage[STAGES-1:FIFO_W];
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= DATA_ZERO;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> bench/vlsr_assertions.sv
// Checker for the shift register top ports
`timescale 1ns/100ps
module vlsr_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic q,
  input wire logic q_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_q_compl: assert property (q_n == !q) else $error("q_n not inverse");
  chk_rst_clear: assert property ($rose(rstn) |-> !q) else $error("q high after reset");
  // Shift-in writes may wait on a full FIFO, so the upper bound is loose
  chk_wr_resp: assert property (s_wr |-> ##[2:300] s_axi_bvalid) else $error("no bvalid");
  chk_wr_early: assert property (s_wr |=> !s_axi_bvalid) else $error("bvalid too soon");
  chk_rd_lat: assert property (s_rd |=> s_axi_rvalid) else $error("rvalid late");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  chk_b_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
endmodule
bind vlsr_top vlsr_chk u_chk (.clk, .rstn, .q, .q_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

// >>> bench/vlsr_partner.sv
// Surrounding logic model: serial data, shift clock, gate and length pins
`timescale 1ns/100ps
module vlsr_partner (
  input  wire logic clk,
  output logic      data_a,
  output logic      data_b,
  output logic      sel_a,
  output logic      shift_clk,
  output logic      clk_gate,
  output logic [5:0] len
);
  initial {data_a, data_b, sel_a, shift_clk, clk_gate, len} = 11'h000;
  // Length pins are only ever changed from here; step also drives the input select
  task automatic hold(input logic [5:0] l, input logic s);
    len   <= l;
    sel_a <= s;
  endtask
  // Mode 0 rising clock, 1 falling gate, 2 rising clock held off by the gate
  task automatic step(input int m, input logic a, input logic b, input logic s);
    @(posedge clk);
    clk_gate <= (m != 0);
    @(posedge clk);
    {data_a, data_b, sel_a} <= {a, b, s};
    shift_clk <= 1'h1;
    if (m == 1) begin
      @(posedge clk);
      clk_gate <= 1'h0;
    end
    @(posedge clk);
    // Hold time over: lines no longer show the old bit
    {data_a, data_b} <= {!a, !b};
    shift_clk <= 1'h0;
    clk_gate <= 1'h0;
  endtask
endmodule

// >>> bench/vlsr_tb.sv
// Self-checking bench for the variable length shift register
`timescale 1ns/100ps
module vlsr_tb;
  import vlsr_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0, q_look = 1'h0, a, b, s, q, q_n;
  logic        data_a, data_b, sel_a, shift_clk, clk_gate;
  logic [5:0]  len;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [33:0] w, got;
  logic [31:0] words[8];
  logic [33:0] expq[$];
  logic [63:0] sr = 64'h0;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0, n_tests = 0, cyc = 0, m, seed = 32'h9eb9;
  always #5 clk = ~clk;
  vlsr_top dut (.clk, .rstn, .data_a, .data_b, .sel_a, .shift_clk, .clk_gate,
    .len_weight_one(len[0]), .len_weight_two(len[1]), .len_weight_four(len[2]),
    .len_weight_eight(len[3]), .len_weight_sixteen(len[4]), .len_weight_thirtytwo(len[5]),
    .q, .q_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  vlsr_partner pin (.clk, .data_a, .data_b, .sel_a, .shift_clk, .clk_gate, .len);
  task end_sim;
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Results are compared at the falling edge, where outputs have settled
  always @(negedge clk) begin
    if (q_look || s_axi_rvalid || s_axi_bvalid) begin
      got = q_look ? {32'h0, q_n, q} : s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} :
        {s_axi_bresp, 32'h0};
      w = expq.pop_front();
      n_tests++;
      if (got !== w) begin
        error_cnt++;
        $display("ERROR %0t: got %h expected %h", $time, got, w);
      end
    end
  end
  always @(posedge clk) if (++cyc == 30000) begin
    error_cnt++;
    end_sim();
  end
  task look(input logic e);
    expq.push_back({32'h0, !e, e});
    q_look <= 1'h1;
    @(posedge clk);
    q_look <= 1'h0;
  endtask
  // Ready is judged at the falling edge and acted on at the next rising edge
  task axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    logic aw, wd, bv;
    expq.push_back({r, 32'h0});
    {s_axi_awaddr, s_axi_wdata} <= {ad, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    bv = 1'h0;
    while (!bv) begin
      @(negedge clk);
      {aw, wd, bv} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready, s_axi_bvalid};
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (wd) s_axi_wvalid <= 1'h0;
    end
  endtask
  task axr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    logic t;
    expq.push_back({r, d});
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    t = 1'h0;
    while (!t) begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end
    s_axi_arvalid <= 1'h0;
    @(posedge clk);
  endtask
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    look(1'h0);
    axr(ADDR_STATUS, 32'h0000_0002);
    axr(ADDR_CTRL, DATA_ZERO);
    for (int c = 0; c < 64; c++) begin
      pin.hold(6'(c), 1'h0);
      for (int i = 0; i < c + 2; i++) begin
        m = $unsigned($random(seed)) % 3;
        {a, b, s} = 3'($random(seed));
        pin.step(m, a, b, s);
        if (m != 2) sr = {sr[62:0], s ? a : b};
        look(sr[c]);
      end
    end
    repeat (60) @(posedge clk);
    look(sr[63]);
    axr(ADDR_STAGES_LO, sr[31:0]);
    axr(ADDR_STAGES_HI, sr[63:32]);
    pin.hold(6'h3f, 1'h1);
    axw(ADDR_CTRL, 32'h0000_0040, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      words[k] = $random(seed);
      axw(ADDR_SHIFT_IN, words[k], RESP_OKAY);
    end
    axr(ADDR_STATUS, {18'h0, 6'h3f, 7'h02, sr[63]});
    axw(ADDR_CTRL, 32'h0000_00c0, RESP_OKAY);
    foreach (words[k]) for (int i = 0; i < 32; i++) sr = {sr[62:0], words[k][i]};
    repeat (400) @(posedge clk);
    axr(ADDR_STATUS, {18'h0, 6'h3f, 7'h01, sr[63]});
    axr(ADDR_STAGES_LO, sr[31:0]);
    axr(ADDR_STAGES_HI, sr[63:32]);
    // Length from the register instead of the pins, back in pin mode
    axw(ADDR_CTRL, 32'h0000_0105, RESP_OKAY);
    axr(ADDR_STATUS, {18'h0, 6'h05, 7'h01, sr[5]});
    look(sr[5]);
    axw(ADDR_STATUS, DATA_ZERO, RESP_SLVERR);
    axw(8'h20, DATA_ZERO, RESP_SLVERR);
    axr(8'h20, DATA_ZERO, RESP_SLVERR);
    rstn <= 1'h0;
    look(1'h0);
    rstn <= 1'h1;
    axr(ADDR_STAGES_HI, DATA_ZERO);
    axr(ADDR_CTRL, DATA_ZERO);
    end_sim();
  end
endmodule
